/* File: design/bgdec_pkg.sv */
/*
 * constants for the branch and group opcode decoder: register map, field
 * positions, reset values, opcode values and the decode class enumeration.
 * assumes a 32-bit apb bus with byte addresses and one word per register.
 */
package bgdec_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_IP = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_OPERAND = 8'h10;
    localparam logic [7:0] ADDR_TARGET = 8'h14;
    localparam logic [7:0] ADDR_SHIFT = 8'h18;
    localparam logic [7:0] ADDR_OPCODE = 8'h1c;
    // ==========================================================
    // field positions
    localparam int FLG_ZERO = 0;
    localparam int FLG_SIGN = 1;
    localparam int FLG_OVF = 2;
    localparam int FLG_CARRY = 3;
    localparam int FLG_PARITY = 4;
    localparam int FLG_IRQEN = 5;
    localparam int STAT_SUB_LSB = 5;
    localparam int STAT_WIDE = 8;
    localparam int STAT_UNDEF = 9;
    localparam int STAT_TAKEN = 10;
    localparam int STAT_LOCK = 11;
    localparam int STAT_WAIT = 12;
    // ==========================================================
    // reset values
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] IP_RST = 16'h0000;
    localparam logic IRQEN_RST = 1'b0;
    // ==========================================================
    // opcodes
    localparam logic [7:0] OP_CALL_NEAR = 8'he8;
    localparam logic [7:0] OP_CALL_FAR = 8'h9a;
    localparam logic [7:0] OP_JMP_NEAR = 8'he9;
    localparam logic [7:0] OP_JMP_SHORT = 8'heb;
    localparam logic [7:0] OP_JMP_FAR = 8'hea;
    localparam logic [7:0] OP_RET_NEAR = 8'hc3;
    localparam logic [7:0] OP_RET_NEAR_REL = 8'hc2;
    localparam logic [7:0] OP_RET_FAR = 8'hcb;
    localparam logic [7:0] OP_RET_FAR_REL = 8'hca;
    localparam logic [7:0] OP_LOOPNZ = 8'he0;
    localparam logic [7:0] OP_LOOPZ = 8'he1;
    localparam logic [7:0] OP_LOOP = 8'he2;
    localparam logic [7:0] OP_COUNT_EMPTY = 8'he3;
    localparam logic [7:0] OP_TRAP_TYPED = 8'hcd;
    localparam logic [7:0] OP_TRAP_BRK = 8'hcc;
    localparam logic [7:0] OP_TRAP_OVF = 8'hce;
    localparam logic [7:0] OP_TRAP_RET = 8'hcf;
    localparam logic [7:0] OP_IRQ_CLR = 8'hfa;
    localparam logic [7:0] OP_IRQ_SET = 8'hfb;
    localparam logic [7:0] OP_WAIT = 8'h9b;
    localparam logic [7:0] OP_LOCK = 8'hf0;
    localparam logic [7:0] BRK_TYPE = 8'h03;
    // ==========================================================
    // decode classes
    typedef enum logic [4:0] {
        CLS_OTHER, CLS_CALL_NEAR, CLS_CALL_FAR, CLS_JMP_NEAR, CLS_JMP_SHORT,
        CLS_JMP_FAR, CLS_RET_NEAR, CLS_RET_FAR, CLS_COND, CLS_LOOP,
        CLS_COUNT_EMPTY, CLS_TRAP, CLS_TRAP_RET, CLS_IRQ_CTRL, CLS_LOCK,
        CLS_WAIT, CLS_ESCAPE, CLS_GRP_IMM, CLS_GRP_SHIFT, CLS_GRP_UN1, CLS_GRP_UN2
    } bgdec_class_e;
endpackage

/* File: design/bgdec_top.sv */
/*
 * branch and group opcode decoder: takes instruction bytes in order, decodes
 * control transfer, group and processor control opcodes, evaluates branch
 * conditions and exposes results over apb.
 * assumes flags, count and ip are loaded by software and bytes arrive in order.
 */
// The APB interface to the registers and the register offsets were left to the implementer.
// How it works
// - low opcode bit selects word or byte
// - s:w 01 fetches two immediate bytes
// - s:w 11 sign-extends one immediate byte
// - shift count one, or count low byte
// - immediate group reg selects eight alu ops
// - shift group reg selects rotates and shifts
// - first unary group reg selection, slot one undefined
// - second unary group selection, slot seven undefined
// - le taken on (sign^ovf)|zero, greater otherwise
// - less taken on sign^ovf, else greater-equal
// - above taken when carry|zero clear
// - above-equal on carry clear, below on set
// - equal on zero set, not-equal clear
// - parity odd on clear, even on set
// - loops decrement count, branch on count, loopz/loopnz also per zero flag
// - typed, breakpoint and overflow traps recognised
// - trap return opcode recognised
// - one opcode clears, next sets irq enable
// - lock prefix holds lock over next instruction
// - escape opcodes hand modrm operand outward
`timescale 1ns/1ps
module bgdec_top #(
    parameter logic [7:0] OVF_TRAP_TYPE = 8'h04
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input logic fetch_valid,
    input logic [7:0] fetch_byte,
    output logic fetch_ready,
    input logic test_in,
    output logic decode_done,
    output logic branch_taken,
    output logic lock_out,
    output logic irq_enable,
    output logic coproc_req,
    output logic wait_stall
);
    // ==========================================================
    // state and storage
    typedef enum logic [2:0] {ST_OP, ST_MODRM, ST_DISP, ST_IMM, ST_EXEC, ST_WAIT} bgdec_state_e;
    bgdec_state_e state_r, state_nxt;
    logic [7:0] op_r, modrm_r;
    logic [1:0] disp_left_r;
    logic [2:0] imm_left_r, imm_cnt_r;
    logic [31:0] imm_r;
    logic [15:0] ip_r, count_r;
    logic [4:0] flags_r;
    logic irq_en_r, lock_r, pready_r, pslverr_r, fetch_ready_r;
    logic done_r, taken_r, coproc_r, wait_r;
    logic [31:0] prdata_r;
    logic [4:0] res_cls_r;
    logic [2:0] res_sub_r;
    logic res_wide_r, res_undef_r;
    logic [15:0] operand_r, tgt_off_r, tgt_seg_r;
    logic [7:0] shift_cnt_r;
    logic acc, wr_en, rd_setup, mapped;
    logic [1:0] disp_in;
    logic [2:0] imm_in;
    logic [15:0] sext8, imm16, cnt_dec, x_operand, x_target;
    logic x_taken, x_undef, x_near;
    bgdec_pkg::bgdec_class_e x_cls;

    // ==========================================================
    // opcode helpers
    function automatic logic needs_modrm(input logic [7:0] op);
        casez (op)
            8'b100000??, 8'b110100??, 8'b1111011?, 8'b1111111?, 8'b11011???: needs_modrm = 1'b1;
            default: needs_modrm = 1'b0;
        endcase
    endfunction

    // immediate bytes after opcode or modrm
    function automatic logic [2:0] imm_len(input logic [7:0] op, input logic [2:0] reg_f);
        casez (op)
            8'b100000??: imm_len = (op[1:0] == 2'b01) ? 3'd2 : 3'd1;
            8'b1111011?: imm_len = (reg_f == 3'b000) ? (op[0] ? 3'd2 : 3'd1) : 3'd0;
            bgdec_pkg::OP_CALL_NEAR, bgdec_pkg::OP_JMP_NEAR: imm_len = 3'd2;
            bgdec_pkg::OP_RET_NEAR_REL, bgdec_pkg::OP_RET_FAR_REL: imm_len = 3'd2;
            bgdec_pkg::OP_CALL_FAR, bgdec_pkg::OP_JMP_FAR: imm_len = 3'd4;
            bgdec_pkg::OP_JMP_SHORT, bgdec_pkg::OP_TRAP_TYPED: imm_len = 3'd1;
            8'b0111????, 8'b111000??: imm_len = 3'd1;
            default: imm_len = 3'd0;
        endcase
    endfunction

    function automatic bgdec_pkg::bgdec_class_e class_of(input logic [7:0] op);
        casez (op)
            bgdec_pkg::OP_CALL_NEAR: class_of = bgdec_pkg::CLS_CALL_NEAR;
            bgdec_pkg::OP_CALL_FAR: class_of = bgdec_pkg::CLS_CALL_FAR;
            bgdec_pkg::OP_JMP_NEAR: class_of = bgdec_pkg::CLS_JMP_NEAR;
            bgdec_pkg::OP_JMP_SHORT: class_of = bgdec_pkg::CLS_JMP_SHORT;
            bgdec_pkg::OP_JMP_FAR: class_of = bgdec_pkg::CLS_JMP_FAR;
            bgdec_pkg::OP_RET_NEAR, bgdec_pkg::OP_RET_NEAR_REL: class_of = bgdec_pkg::CLS_RET_NEAR;
            bgdec_pkg::OP_RET_FAR, bgdec_pkg::OP_RET_FAR_REL: class_of = bgdec_pkg::CLS_RET_FAR;
            bgdec_pkg::OP_COUNT_EMPTY: class_of = bgdec_pkg::CLS_COUNT_EMPTY;
            bgdec_pkg::OP_TRAP_RET: class_of = bgdec_pkg::CLS_TRAP_RET;
            bgdec_pkg::OP_IRQ_CLR, bgdec_pkg::OP_IRQ_SET: class_of = bgdec_pkg::CLS_IRQ_CTRL;
            bgdec_pkg::OP_LOCK: class_of = bgdec_pkg::CLS_LOCK;
            bgdec_pkg::OP_WAIT: class_of = bgdec_pkg::CLS_WAIT;
            8'b110011??: class_of = bgdec_pkg::CLS_TRAP;
            8'b111000??: class_of = bgdec_pkg::CLS_LOOP;
            8'b0111????: class_of = bgdec_pkg::CLS_COND;
            8'b11011???: class_of = bgdec_pkg::CLS_ESCAPE;
            8'b100000??: class_of = bgdec_pkg::CLS_GRP_IMM;
            8'b110100??: class_of = bgdec_pkg::CLS_GRP_SHIFT;
            8'b1111011?: class_of = bgdec_pkg::CLS_GRP_UN1;
            8'b1111111?: class_of = bgdec_pkg::CLS_GRP_UN2;
            default: class_of = bgdec_pkg::CLS_OTHER;
        endcase
    endfunction

    // conditional branch test: op[3:1] picks the base term, op[0] inverts it
    function automatic logic cond_true(input logic [3:0] cc, input logic [4:0] f);
        logic base;
        logic sxo;
        sxo = f[bgdec_pkg::FLG_SIGN] ^ f[bgdec_pkg::FLG_OVF];
        unique case (cc[3:1])
            3'd0: base = f[bgdec_pkg::FLG_OVF];
            3'd1: base = f[bgdec_pkg::FLG_CARRY];
            3'd2: base = f[bgdec_pkg::FLG_ZERO];
            3'd3: base = f[bgdec_pkg::FLG_CARRY] | f[bgdec_pkg::FLG_ZERO];
            3'd4: base = f[bgdec_pkg::FLG_SIGN];
            3'd5: base = f[bgdec_pkg::FLG_PARITY];
            3'd6: base = sxo;
            3'd7: base = sxo | f[bgdec_pkg::FLG_ZERO];
        endcase
        cond_true = base ^ cc[0];
    endfunction

    // ==========================================================
    // fetch sequencing
    assign acc = fetch_valid & fetch_ready_r;
    assign disp_in = (fetch_byte[7:6] == 2'b01) ? 2'd1 :
                     ((fetch_byte[7:6] == 2'b10) ||
                      (fetch_byte[7:6] == 2'b00 && fetch_byte[2:0] == 3'b110)) ? 2'd2 : 2'd0;
    assign imm_in = (state_r == ST_OP) ? imm_len(fetch_byte, 3'b000) : imm_len(op_r, fetch_byte[5:3]);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OP: begin
                if (acc) begin
                    if (needs_modrm(fetch_byte)) begin
                        state_nxt = ST_MODRM;
                    end else if (imm_in != 3'd0) begin
                        state_nxt = ST_IMM;
                    end else if (fetch_byte == bgdec_pkg::OP_WAIT) begin
                        state_nxt = ST_WAIT;
                    end else begin
                        state_nxt = ST_EXEC;
                    end
                end
            end
            ST_MODRM: begin
                if (acc) begin
                    state_nxt = (disp_in != 2'd0) ? ST_DISP : (imm_in != 3'd0) ? ST_IMM : ST_EXEC;
                end
            end
            ST_DISP: begin
                if (acc && disp_left_r == 2'd1) begin
                    state_nxt = (imm_left_r != 3'd0) ? ST_IMM : ST_EXEC;
                end
            end
            ST_IMM: begin
                if (acc && imm_left_r == 3'd1) begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: state_nxt = ST_OP;
            ST_WAIT: state_nxt = test_in ? ST_EXEC : ST_WAIT;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_OP;
            fetch_ready_r <= 1'b0;
            wait_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            fetch_ready_r <= (state_nxt != ST_EXEC) && (state_nxt != ST_WAIT);
            wait_r <= (state_nxt == ST_WAIT);
        end
    end

    // byte capture; displacement bytes of the modrm address form are skipped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_r <= 8'h00;
            modrm_r <= 8'h00;
            disp_left_r <= 2'd0;
            imm_left_r <= 3'd0;
            imm_cnt_r <= 3'd0;
            imm_r <= 32'h0000_0000;
        end else if (acc) begin
            unique case (state_r)
                ST_OP: begin
                    op_r <= fetch_byte;
                    modrm_r <= 8'h00;
                    imm_left_r <= imm_in;
                    imm_cnt_r <= 3'd0;
                    imm_r <= 32'h0000_0000;
                end
                ST_MODRM: begin
                    modrm_r <= fetch_byte;
                    disp_left_r <= disp_in;
                    imm_left_r <= imm_in;
                end
                ST_DISP: disp_left_r <= disp_left_r - 2'd1;
                ST_IMM: begin
                    // low byte first, then high, then segment bytes
                    imm_r[{imm_cnt_r[1:0], 3'b000} +: 8] <= fetch_byte;
                    imm_cnt_r <= imm_cnt_r + 3'd1;
                    imm_left_r <= imm_left_r - 3'd1;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // execute stage
    assign sext8 = {{8{imm_r[7]}}, imm_r[7:0]};
    assign imm16 = imm_r[15:0];
    assign cnt_dec = count_r - 16'h0001;
    assign x_cls = class_of(op_r);

    always_comb begin
        x_taken = 1'b0;
        x_near = 1'b0;
        x_target = ip_r;
        x_operand = imm16;
        x_undef = 1'b0;
        unique case (x_cls)
            bgdec_pkg::CLS_CALL_NEAR, bgdec_pkg::CLS_JMP_NEAR: begin
                x_taken = 1'b1;
                x_near = 1'b1;
                x_target = ip_r + imm16;
            end
            bgdec_pkg::CLS_JMP_SHORT: begin
                x_taken = 1'b1;
                x_near = 1'b1;
                x_target = ip_r + sext8;
            end
            bgdec_pkg::CLS_CALL_FAR, bgdec_pkg::CLS_JMP_FAR: begin
                x_taken = 1'b1;
                x_target = imm16;
            end
            bgdec_pkg::CLS_COND: begin
                x_taken = cond_true(op_r[3:0], flags_r);
                x_near = 1'b1;
                x_target = ip_r + sext8;
            end
            bgdec_pkg::CLS_LOOP: begin
                unique case (op_r[1:0])
                    2'b10: x_taken = (cnt_dec != 16'h0000);
                    2'b01: x_taken = (cnt_dec != 16'h0000) & flags_r[bgdec_pkg::FLG_ZERO];
                    2'b00: x_taken = (cnt_dec != 16'h0000) & ~flags_r[bgdec_pkg::FLG_ZERO];
                    default: x_taken = 1'b0;
                endcase
                x_near = 1'b1;
                x_target = ip_r + sext8;
            end
            bgdec_pkg::CLS_COUNT_EMPTY: begin
                x_taken = (count_r == 16'h0000);
                x_near = 1'b1;
                x_target = ip_r + sext8;
            end
            bgdec_pkg::CLS_TRAP: begin
                unique case (op_r[1:0])
                    2'b01: begin
                        x_taken = 1'b1;
                        x_operand = {8'h00, imm_r[7:0]};
                    end
                    2'b00: begin
                        x_taken = 1'b1;
                        x_operand = {8'h00, bgdec_pkg::BRK_TYPE};
                    end
                    default: begin
                        // the trap-return code shares this row but is its own class
                        x_taken = flags_r[bgdec_pkg::FLG_OVF];
                        x_operand = {8'h00, OVF_TRAP_TYPE};
                    end
                endcase
            end
            bgdec_pkg::CLS_GRP_IMM: begin
                if (op_r[1:0] == 2'b01) begin
                    x_operand = imm16;
                end else if (op_r[1:0] == 2'b11) begin
                    x_operand = sext8;
                end else begin
                    x_operand = {8'h00, imm_r[7:0]};
                end
            end
            bgdec_pkg::CLS_GRP_SHIFT: x_undef = (modrm_r[5:3] == 3'b110);
            bgdec_pkg::CLS_GRP_UN1: begin
                x_undef = (modrm_r[5:3] == 3'b001);
                x_operand = op_r[0] ? imm16 : {8'h00, imm_r[7:0]};
            end
            bgdec_pkg::CLS_GRP_UN2: x_undef = (modrm_r[5:3] == 3'b111);
            default: begin
            end
        endcase
    end

    // results; the group sub-op is the reg field itself, in table order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_cls_r <= 5'h00;
            res_sub_r <= 3'b000;
            res_wide_r <= 1'b0;
            res_undef_r <= 1'b0;
            operand_r <= 16'h0000;
            tgt_off_r <= 16'h0000;
            tgt_seg_r <= 16'h0000;
            shift_cnt_r <= 8'h00;
            done_r <= 1'b0;
            taken_r <= 1'b0;
            coproc_r <= 1'b0;
        end else begin
            done_r <= (state_r == ST_EXEC);
            coproc_r <= (state_r == ST_EXEC) && (x_cls == bgdec_pkg::CLS_ESCAPE);
            if (state_r == ST_EXEC) begin
                res_cls_r <= x_cls;
                res_sub_r <= modrm_r[5:3];
                res_wide_r <= op_r[0];
                res_undef_r <= x_undef;
                operand_r <= x_operand;
                tgt_off_r <= x_target;
                tgt_seg_r <= imm_r[31:16];
                shift_cnt_r <= op_r[1] ? count_r[7:0] : 8'h01;
                taken_r <= x_taken;
            end
        end
    end

    // ==========================================================
    // architectural state; decoder updates win over a software write
    assign wr_en = psel & penable & pwrite & pready_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ip_r <= bgdec_pkg::IP_RST;
        end else if (state_r == ST_EXEC && x_taken && (x_near || x_cls == bgdec_pkg::CLS_JMP_FAR ||
                     x_cls == bgdec_pkg::CLS_CALL_FAR)) begin
            ip_r <= x_target;
        end else if (acc) begin
            ip_r <= ip_r + 16'h0001;
        end else if (wr_en && paddr == bgdec_pkg::ADDR_IP) begin
            ip_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= bgdec_pkg::COUNT_RST;
        end else if (state_r == ST_EXEC && x_cls == bgdec_pkg::CLS_LOOP) begin
            count_r <= cnt_dec;
        end else if (wr_en && paddr == bgdec_pkg::ADDR_COUNT) begin
            count_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= bgdec_pkg::FLAGS_RST;
            irq_en_r <= bgdec_pkg::IRQEN_RST;
        end else begin
            if (wr_en && paddr == bgdec_pkg::ADDR_FLAGS) begin
                flags_r <= pwdata[4:0];
            end
            if (state_r == ST_EXEC && x_cls == bgdec_pkg::CLS_IRQ_CTRL) begin
                irq_en_r <= op_r[0];
            end else if (wr_en && paddr == bgdec_pkg::ADDR_FLAGS) begin
                irq_en_r <= pwdata[bgdec_pkg::FLG_IRQEN];
            end
        end
    end

    // lock rises with the prefix and falls when the next instruction ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= 1'b0;
        end else if (state_r == ST_EXEC) begin
            lock_r <= (x_cls == bgdec_pkg::CLS_LOCK);
        end
    end

    // ==========================================================
    // apb slave: zero wait states, read data sampled in the setup cycle
    assign rd_setup = psel & ~penable;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= bgdec_pkg::ADDR_OPCODE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= rd_setup;
            pslverr_r <= rd_setup & ~mapped;
            if (rd_setup && !pwrite) begin
                unique case (paddr)
                    bgdec_pkg::ADDR_FLAGS: prdata_r <= {26'h0, irq_en_r, flags_r};
                    bgdec_pkg::ADDR_COUNT: prdata_r <= {16'h0000, count_r};
                    bgdec_pkg::ADDR_IP: prdata_r <= {16'h0000, ip_r};
                    bgdec_pkg::ADDR_STATUS: prdata_r <= {19'h0, wait_r, lock_r, taken_r,
                                                        res_undef_r, res_wide_r, res_sub_r, res_cls_r};
                    bgdec_pkg::ADDR_OPERAND: prdata_r <= {16'h0000, operand_r};
                    bgdec_pkg::ADDR_TARGET: prdata_r <= {tgt_seg_r, tgt_off_r};
                    bgdec_pkg::ADDR_SHIFT: prdata_r <= {24'h000000, shift_cnt_r};
                    bgdec_pkg::ADDR_OPCODE: prdata_r <= {16'h0000, modrm_r, op_r};
                    default: prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==========================================================
    // outputs
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;
    assign fetch_ready = fetch_ready_r;
    assign decode_done = done_r;
    assign branch_taken = taken_r;
    assign lock_out = lock_r;
    assign irq_enable = irq_en_r;
    assign coproc_req = coproc_r;
    assign wait_stall = wait_r;
endmodule

/* File: bench/bgdec_props.sv */
/* checker: apb answer timing, decode pulses, held results
   sees only the bgdec_top ports, attached by the bind below */
`timescale 1ns/1ps
module bgdec_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic fetch_ready,
    input wire logic decode_done,
    input wire logic branch_taken,
    input wire logic irq_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // apb
    chk_pready_one: assert property (psel && !penable |=> pready) else $error("late pready");
    chk_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
    chk_err_unmapped: assert property (psel && !penable && paddr > 8'h1c |=> pslverr)
        else $error("no slverr");
    chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("error read not zero");
    // ==========
    // decode
    chk_done_pulse: assert property (decode_done |=> !decode_done) else $error("done held");
    chk_exec_gap: assert property (decode_done |-> !$past(fetch_ready)) else $error("no gap");
    chk_taken_hold: assert property ($changed(branch_taken) |-> decode_done)
        else $error("taken moved");
    chk_irq_hold: assert property ($changed(irq_enable) |-> decode_done ||
        $past(psel) && $past(penable) && $past(pwrite)) else $error("irq moved");
endmodule
bind bgdec_top bgdec_props u_chk (.*);

/* File: bench/bgdec_fetch_model.sv */
/* fetch model: program bytes queued by the bench, offered in order
   assumes the decoder takes a byte on valid and ready */
`timescale 1ns/1ps
module bgdec_fetch_model (
    input wire logic pclk,
    input wire logic fetch_ready,
    output logic fetch_valid,
    output logic [7:0] fetch_byte
);
    logic [7:0] mem [64];
    int wq = 0;
    int wp = 0;
    int rp = 0;
    // bytes are staged, then shown by one nonblocking update so no edge races them
    task push(input logic [7:0] b);
        mem[wq] = b;
        wq++;
    endtask
    task commit;
        wp <= wq;
    endtask
    assign fetch_valid = rp != wp;
    // idle bus churns so a stale byte is never mistaken for a real one
    assign fetch_byte = fetch_valid ? mem[rp] : 8'h5a ^ rp[7:0];
    always @(posedge pclk) if (fetch_valid && fetch_ready) rp <= rp + 1;
endmodule

/* File: bench/branch_and_group_opcode_decoder_tb.sv */
/* bench: apb register access and instruction streams with expected results
   assumes the fetch model and checker files are compiled first */
`timescale 1ns/1ps
module branch_and_group_opcode_decoder_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, test_in = 0, er;
    logic [7:0] paddr = 0, fetch_byte;
    logic [31:0] pwdata = 0, rd, prdata;
    logic pready, pslverr, fetch_valid, fetch_ready, decode_done, branch_taken;
    logic lock_out, irq_enable, coproc_req, wait_stall;
    int failures = 0, checks = 0;
    // op, flags, taken
    logic [19:0] cs [15] = '{20'h7f001, 20'h7f010, 20'h7e060, 20'h7c021, 20'h7d020,
        20'h77080, 20'h76000, 20'h73001, 20'h72081, 20'h75010, 20'h74011, 20'h7b100,
        20'h7a101, 20'h70041, 20'h79020};
    initial forever #2.5 pclk = ~pclk;
    bgdec_top u_dut (.*);
    bgdec_fetch_model u_fm (.*);
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    endtask
    task ex(input int n, input logic [31:0] bs);
        for (int i = 0; i < n; i++) u_fm.push(bs[8*i+:8]);
        u_fm.commit;
        do @(posedge pclk); while (decode_done !== 1'b1);
    endtask
    task finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        finish_test;
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        apb(0, bgdec_pkg::ADDR_FLAGS, 0); chk("flags", rd, 0);
        apb(0, 8'h20, 0); chk("slverr", er, 1);
        apb(1, bgdec_pkg::ADDR_IP, 32'h100); ex(2, 16'hfeeb);
        apb(0, bgdec_pkg::ADDR_IP, 0); chk("ip", rd, 32'h100);
        for (int i = 0; i < 15; i++) begin
            apb(1, bgdec_pkg::ADDR_FLAGS, {24'h0, cs[i][11:4]});
            ex(2, {8'h02, cs[i][19:12]});
            chk("taken", branch_taken, cs[i][0]);
        end
        ex(3, 24'hffc083); apb(0, bgdec_pkg::ADDR_OPERAND, 0); chk("sext", rd, 32'hffff);
        ex(4, 32'h1234c081); apb(0, bgdec_pkg::ADDR_OPERAND, 0); chk("imm", rd, 32'h1234);
        apb(0, bgdec_pkg::ADDR_STATUS, 0); chk("word", rd[8], 1);
        ex(1, 8'hf0);
        chk("lock", lock_out, 1);
        ex(1, 8'hfb); chk("irq", irq_enable, 1);
        chk("lock", lock_out, 0);
        ex(1, 8'hfa); chk("irq", irq_enable, 0);
        apb(1, bgdec_pkg::ADDR_COUNT, 1); ex(2, 16'h02e2); chk("loop", branch_taken, 0);
        apb(0, bgdec_pkg::ADDR_COUNT, 0); chk("count", rd, 0);
        ex(2, 16'h02e3);
        chk("empty", branch_taken, 1);
        apb(1, bgdec_pkg::ADDR_COUNT, 32'h0305);
        ex(2, 16'he8d3);
        apb(0, bgdec_pkg::ADDR_SHIFT, 0);
        chk("count_low_byte", rd, 32'h05);
        ex(2, 16'he8d1);
        apb(0, bgdec_pkg::ADDR_SHIFT, 0);
        chk("shift", rd, 1);
        apb(0, bgdec_pkg::ADDR_STATUS, 0);
        chk("sub", rd[7:5], 5);
        ex(2, 16'h21cd);
        apb(0, bgdec_pkg::ADDR_OPERAND, 0);
        chk("trap", rd, 32'h21);
        ex(1, 8'hcc);
        apb(0, bgdec_pkg::ADDR_OPERAND, 0);
        chk("brk", rd, 3);
        ex(1, 8'hcf);
        apb(0, bgdec_pkg::ADDR_STATUS, 0);
        chk("class", rd[4:0], bgdec_pkg::CLS_TRAP_RET);
        ex(2, 16'hc0d8);
        chk("coproc", coproc_req, 1);
        u_fm.push(bgdec_pkg::OP_WAIT);
        u_fm.commit;
        repeat (6) @(posedge pclk);
        chk("stall", wait_stall, 1);
        test_in <= 1;
        ex(0, 0);
        test_in <= 0;
        chk("stall", wait_stall, 0);
        finish_test;
    end
endmodule
